// >>> hw/fiowd_pkg.sv
package fiowd_pkg;

  // ==========================================
  // Parameter selector codes
  localparam logic [3:0] SEL_NV_SPEED   = 4'h0;
  localparam logic [3:0] SEL_NV_UNIT    = 4'h1;
  localparam logic [3:0] SEL_UNIT       = 4'h2;
  localparam logic [3:0] SEL_NV_PERIOD  = 4'h3;
  localparam logic [3:0] SEL_PERIOD     = 4'h4;
  localparam logic [3:0] SEL_OUTPUT     = 4'h5;
  localparam logic [3:0] SEL_INPUT      = 4'h6;
  localparam logic [3:0] SEL_FAULT      = 4'h7;
  localparam logic [3:0] SEL_STATUS     = 4'h8;

  // ==========================================
  // Reset values of the stored parameters
  localparam logic [15:0] RST_NV_SPEED  = 16'h0009;
  localparam logic [31:0] RST_NV_UNIT   = 32'h00000000;
  localparam logic [15:0] RST_NV_PERIOD = 16'h0032;

  // ==========================================
  // Fault and status bit positions
  localparam int FLT_WATCHDOG = 0;
  localparam int FLT_OVERCUR  = 1;
  localparam int FLT_OVERTEMP = 2;
  localparam int FLT_FIELD    = 3;
  localparam int FLT_POWERUP  = 4;
  localparam logic [15:0] RST_FAULT = 16'h0010;
  localparam int STS_FIELD_OK   = 0;
  localparam int STS_FIELD_LOST = 1;
  localparam int STS_FAULT      = 2;
  localparam int STS_RUNNING    = 3;

  // ==========================================
  // Thresholds and timing
  localparam logic [15:0] HYST_HI_PCT    = 16'h003C;
  localparam logic [15:0] HYST_LO_PCT    = 16'h0028;
  localparam logic [7:0]  FIELD_MIN_CODE = 8'h38;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WD_UNIT_NS    = 1000000;
  localparam int WD_UNIT_CYC   = WD_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic {FIOWD_LOAD, FIOWD_RUN} fiowd_phase_t;

  function automatic logic fiowd_sel_valid(input logic [3:0] sel);
    fiowd_sel_valid = (sel <= SEL_STATUS);
  endfunction

  // Code at or above pct percent of the field code
  function automatic logic fiowd_at_least(input logic [7:0] code, input logic [7:0] field,
                                          input logic [15:0] pct);
    fiowd_at_least = (16'(code) * 16'h0064) >= (16'(field) * pct);
  endfunction

endpackage

// >>> hw/fiowd_hyst.sv
`timescale 1ns/10ps
`default_nettype none
module fiowd_hyst
  import fiowd_pkg::*;
#(
  parameter int N = 32
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 ce,
  input  wire logic [N-1:0][7:0]    level_code,
  input  wire logic [7:0]           field_code,
  output logic      [N-1:0]         level
);

  typedef struct packed {
    logic [N-1:0] level;
  } fiowd_hyst_t;

  fiowd_hyst_t st;
  fiowd_hyst_t next_st;

  always_comb begin
    next_st = st;
    if (ce) begin
      for (int i = 0; i < N; i++) begin
        // Between the thresholds the last level holds
        if (fiowd_at_least(level_code[i], field_code, HYST_HI_PCT)) begin
          next_st.level[i] = 1'b1;
        end else if (!fiowd_at_least(level_code[i], field_code, HYST_LO_PCT)) begin
          next_st.level[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_hyst_rise_high: assert property (ce && fiowd_at_least(level_code[0], field_code, HYST_HI_PCT)
    |=> level[0]) else $error("input 0 not high above upper threshold");
  a_hyst_fall_low: assert property (ce && !fiowd_at_least(level_code[0], field_code, HYST_LO_PCT)
    |=> !level[0]) else $error("input 0 not low below lower threshold");
  a_hyst_hold_band: assert property (ce && fiowd_at_least(level_code[0], field_code, HYST_LO_PCT)
    && !fiowd_at_least(level_code[0], field_code, HYST_HI_PCT) |=> level[0] == $past(level[0]))
    else $error("input 0 changed inside hysteresis band");

endmodule // fiowd_hyst
`default_nettype wire

// >>> hw/fiowd_top.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - 32 inputs and 16 outputs, independent
// - Overcurrent forces that output off, faults
// - Chip overtemperature disables its outputs, faults
// - Each chip serves 8 consecutive outputs
// - Input high at 60%, low at 40%
// - Input voltage read as 8-bit code
// - Modes 1, 2 return analog inputs 0-3
// - Report field loss when separately supplied
// - Watchdog timeout sets fault, outputs off
// - Output writes ignored while faulted; host clears
// - Powers up faulted; host clears first
// - Outputs one 16-bit word, inputs 32-bit
// - Working watchdog period in ms governs timeout
// - Unit identifier: non-volatile and working copies
// - Config indicators off in normal operation
// - Power-up copies non-volatile into working values
// - Watchdog period zero disables watchdog
module fiowd_top
  import fiowd_pkg::*;
#(
  parameter int N_IN         = 32,
  parameter int N_OUT        = 16,
  parameter int OUT_PER_CHIP = 8,
  parameter int TICK_CYC     = WD_UNIT_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  input  wire logic                   param_rd,
  input  wire logic                   param_wr,
  input  wire logic [3:0]             param_sel,
  input  wire logic [31:0]            param_wdata,
  output logic      [31:0]            param_rdata,
  output logic                        param_ack,
  output logic                        param_err,
  input  wire logic [1:0]             pd_mode,
  input  wire logic [N_IN-1:0][7:0]   in_level_code,
  input  wire logic [7:0]             field_code,
  input  wire logic                   separate_supply,
  input  wire logic [N_OUT-1:0]       drv_overcurrent,
  input  wire logic [N_OUT/OUT_PER_CHIP-1:0] drv_overtemp,
  output logic      [N_OUT-1:0]       field_out,
  output logic      [3:0][7:0]        analog_in_0_3,
  output logic      [7:0]             field_report,
  output logic                        cfg_init_indicator,
  output logic                        cfg_done_indicator,
  output logic                        field_power_indicator,
  output logic                        logic_power_indicator,
  output logic                        power_fail_indicator
);

  localparam int N_CHIP = N_OUT / OUT_PER_CHIP;

  // ==========================================
  // Elaboration checks
  if (N_IN != 32 || N_OUT != 16) begin : g_bad_width
    $error("fiowd_top: words are fixed at 32 inputs and 16 outputs");
  end
  if (OUT_PER_CHIP < 1 || (N_OUT % OUT_PER_CHIP) != 0) begin : g_bad_chip
    $error("fiowd_top: outputs must split evenly across driver chips");
  end
  if (TICK_CYC < 1) begin : g_bad_tick
    $error("fiowd_top: millisecond tick must be at least one cycle");
  end

  typedef struct packed {
    fiowd_phase_t      phase;
    logic [15:0]       nv_speed;
    logic [31:0]       nv_unit;
    logic [31:0]       unit;
    logic [15:0]       nv_period;
    logic [15:0]       period;
    logic [15:0]       out_word;
    logic [15:0]       fault;
    logic [15:0]       oc_off;
    logic [15:0]       ot_off;
    logic [31:0]       tick_cnt;
    logic [15:0]       ms_cnt;
    logic [15:0]       field_out;
    logic [31:0]       rdata;
    logic              ack;
    logic              err;
    logic [3:0][7:0]   analog;
    logic [7:0]        field_rpt;
    logic              cfg_ind;
    logic              field_lost;
  } fiowd_state_t;

  fiowd_state_t st;
  fiowd_state_t next_st;
  logic [N_IN-1:0] in_level;
  logic            access_ok;
  logic            field_low;
  logic [15:0]     clr;
  logic [15:0]     set;
  logic [15:0]     ot_mask;
  logic [15:0]     status;
  logic [15:0]     next_ms;

  // ==========================================
  // Input classification
  fiowd_hyst #(
    .N (N_IN)
  ) u_hyst (
    .clk        (clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .level_code (in_level_code),
    .field_code (field_code),
    .level      (in_level)
  );

  assign access_ok = (param_rd | param_wr) & fiowd_sel_valid(param_sel);
  assign field_low = field_code < FIELD_MIN_CODE;
  assign status    = {12'h000, st.phase == FIOWD_RUN, |st.fault, st.field_lost, !field_low};

  // ==========================================
  // Next state
  always_comb begin
    next_st = st;
    clr     = 16'h0000;
    set     = 16'h0000;
    ot_mask = 16'h0000;
    next_ms = st.ms_cnt;
    if (ce) begin
      next_st.ack = 1'b0;
      next_st.err = 1'b0;
      if (st.phase == FIOWD_LOAD) begin
        next_st.period  = st.nv_period;
        next_st.unit    = st.nv_unit;
        next_st.cfg_ind = 1'b0;
        next_st.phase   = FIOWD_RUN;
      end else begin
        // Host parameter access
        if (param_rd | param_wr) begin
          next_st.ack   = 1'b1;
          next_st.err   = !access_ok;
          next_st.rdata = 32'h00000000;
        end
        // A write wins when both strobes are high
        if (param_wr) begin
          case (param_sel)
            SEL_NV_SPEED:  next_st.nv_speed  = param_wdata[15:0];
            SEL_NV_UNIT:   next_st.nv_unit   = param_wdata;
            SEL_UNIT:      next_st.unit      = param_wdata;
            SEL_NV_PERIOD: next_st.nv_period = param_wdata[15:0];
            SEL_PERIOD:    next_st.period    = param_wdata[15:0];
            SEL_OUTPUT: begin
              if (st.fault == 16'h0000) begin
                next_st.out_word = param_wdata[15:0];
              end
            end
            SEL_FAULT:     clr = param_wdata[15:0];
            default: ;
          endcase
        end else if (param_rd) begin
          case (param_sel)
            SEL_NV_SPEED:  next_st.rdata = {16'h0000, st.nv_speed};
            SEL_NV_UNIT:   next_st.rdata = st.nv_unit;
            SEL_UNIT:      next_st.rdata = st.unit;
            SEL_NV_PERIOD: next_st.rdata = {16'h0000, st.nv_period};
            SEL_PERIOD:    next_st.rdata = {16'h0000, st.period};
            SEL_OUTPUT:    next_st.rdata = {16'h0000, st.out_word};
            SEL_INPUT:     next_st.rdata = in_level;
            SEL_FAULT:     next_st.rdata = {16'h0000, st.fault};
            SEL_STATUS:    next_st.rdata = {16'h0000, status};
            default:       next_st.rdata = 32'h00000000;
          endcase
        end

        // Watchdog, counted in whole milliseconds
        // Unmapped selectors leave the count running
        if (access_ok) begin
          next_st.tick_cnt = 32'h00000000;
          next_st.ms_cnt   = 16'h0000;
        end else if (st.period == 16'h0000 || st.fault[FLT_WATCHDOG]) begin
          next_st.tick_cnt = 32'h00000000;
          next_st.ms_cnt   = 16'h0000;
        end else if (st.tick_cnt == 32'(TICK_CYC - 1)) begin
          next_st.tick_cnt = 32'h00000000;
          next_ms          = st.ms_cnt + 16'h0001;
          next_st.ms_cnt   = next_ms;
          if (next_ms >= st.period) begin
            set[FLT_WATCHDOG] = 1'b1;
          end
        end else begin
          next_st.tick_cnt = st.tick_cnt + 32'h00000001;
        end

        // Driver protection
        if (|drv_overcurrent) begin
          set[FLT_OVERCUR] = 1'b1;
        end
        // Chip c owns a run of OUT_PER_CHIP outputs
        for (int c = 0; c < N_CHIP; c++) begin
          if (drv_overtemp[c]) begin
            set[FLT_OVERTEMP] = 1'b1;
            for (int b = 0; b < OUT_PER_CHIP; b++) begin
              ot_mask[c * OUT_PER_CHIP + b] = 1'b1;
            end
          end
        end
        // Loss only matters when the processor has its own supply
        next_st.field_lost = separate_supply & field_low;
        if (separate_supply & field_low) begin
          set[FLT_FIELD] = 1'b1;
        end

        // Set wins over a clear in the same cycle
        next_st.fault  = (st.fault & ~clr) | set;
        next_st.oc_off = (st.oc_off & ~{16{clr[FLT_OVERCUR]}}) | drv_overcurrent;
        next_st.ot_off = (st.ot_off & ~{16{clr[FLT_OVERTEMP]}}) | ot_mask;

        // Process data extras
        for (int a = 0; a < 4; a++) begin
          next_st.analog[a] = (pd_mode == 2'h1 || pd_mode == 2'h2) ? in_level_code[a] : 8'h00;
        end
        next_st.field_rpt = (pd_mode == 2'h2) ? field_code : 8'h00;
      end
      // Outputs follow the settled word and masks; any fault turns all off
      next_st.field_out = (next_st.fault == 16'h0000) ?
                          (next_st.out_word & ~next_st.oc_off & ~next_st.ot_off) : 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Comes up faulted; the host must clear before driving
      st           <= '0;
      st.phase     <= FIOWD_LOAD;
      st.nv_speed  <= RST_NV_SPEED;
      st.nv_unit   <= RST_NV_UNIT;
      st.nv_period <= RST_NV_PERIOD;
      st.fault     <= RST_FAULT;
      st.cfg_ind   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Outputs
  assign param_rdata           = st.rdata;
  assign param_ack             = st.ack;
  assign param_err             = st.err;
  assign field_out             = st.field_out;
  assign analog_in_0_3         = st.analog;
  assign field_report          = st.field_rpt;
  assign cfg_init_indicator    = st.cfg_ind;
  assign cfg_done_indicator    = st.cfg_ind;
  assign field_power_indicator = !st.field_lost;
  assign logic_power_indicator = st.phase == FIOWD_RUN;
  assign power_fail_indicator  = st.field_lost;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_fault_outputs_off: assert property ((st.fault != 16'h0000) |-> field_out == 16'h0000)
    else $error("output driven while fault set");
  a_out_write_ignored: assert property (ce && st.phase == FIOWD_RUN && param_wr && param_sel == SEL_OUTPUT
    && st.fault != 16'h0000 |=> st.out_word == $past(st.out_word))
    else $error("output word changed while faulted");
  a_oc_forces_off: assert property (ce && st.phase == FIOWD_RUN && |drv_overcurrent
    |=> (field_out & $past(drv_overcurrent)) == 16'h0000 && st.fault[FLT_OVERCUR])
    else $error("overcurrent output not forced off");
  a_ot_chip_off: assert property (ce && st.phase == FIOWD_RUN && drv_overtemp[0]
    |=> field_out[OUT_PER_CHIP-1:0] == '0 && st.fault[FLT_OVERTEMP])
    else $error("overtemperature chip outputs not disabled");
  a_powerup_faulted: assert property (st.phase == FIOWD_LOAD |-> st.fault[FLT_POWERUP])
    else $error("not faulted at power-up");
  a_nv_copy_load: assert property (ce && st.phase == FIOWD_LOAD
    |=> st.period == $past(st.nv_period) && st.unit == $past(st.nv_unit))
    else $error("working values not loaded from non-volatile");
  a_wd_zero_off: assert property (ce && st.period == 16'h0000 && !param_wr
    |=> !$rose(st.fault[FLT_WATCHDOG])) else $error("watchdog bit with zero period");
  a_wd_restart: assert property (ce && st.phase == FIOWD_RUN && access_ok
    |=> st.ms_cnt == 16'h0000 && st.tick_cnt == 32'h00000000)
    else $error("access did not restart watchdog");
  a_wd_bite_period: assert property ($rose(st.fault[FLT_WATCHDOG])
    |-> $past(st.period) != 16'h0000 && st.ms_cnt >= $past(st.period))
    else $error("watchdog bit before working period");
  a_input_word_map: assert property (ce && st.phase == FIOWD_RUN && param_rd && !param_wr
    && param_sel == SEL_INPUT |=> param_rdata == $past(in_level))
    else $error("input word read mismatch");
  a_cfg_ind_off: assert property (st.phase == FIOWD_RUN |-> !cfg_init_indicator && !cfg_done_indicator)
    else $error("configuration indicator lit in operation");
  a_analog_mode0: assert property (ce && st.phase == FIOWD_RUN && pd_mode == 2'h0
    |=> analog_in_0_3 == '0) else $error("analog data outside modes 1 and 2");
  a_field_loss: assert property (ce && st.phase == FIOWD_RUN && separate_supply && field_low
    |=> st.field_lost && st.fault[FLT_FIELD]) else $error("field loss not reported");

  // ==========================================
  // Access checks
  a_ack_follows_req: assert property (ce && st.phase == FIOWD_RUN && (param_rd || param_wr)
    |=> param_ack && param_err == !$past(access_ok))
    else $error("request not answered one cycle later");
  a_unit_write: assert property (ce && st.phase == FIOWD_RUN && param_wr && param_sel == SEL_UNIT
    |=> st.unit == $past(param_wdata))
    else $error("working unit identifier not written");
  a_nv_period_defer: assert property (ce && st.phase == FIOWD_RUN && param_wr && param_sel == SEL_NV_PERIOD
    |=> st.period == $past(st.period))
    else $error("non-volatile period write changed working period");
  a_out_write_taken: assert property (ce && st.phase == FIOWD_RUN && param_wr && param_sel == SEL_OUTPUT
    && st.fault == 16'h0000 |=> st.out_word == $past(param_wdata[15:0]))
    else $error("output word write lost with no fault");
  a_fault_sticky: assert property (ce && st.phase == FIOWD_RUN && st.fault[FLT_POWERUP]
    && !(param_wr && param_sel == SEL_FAULT) |=> st.fault[FLT_POWERUP])
    else $error("power-up fault cleared without host write");

  // ==========================================
  // Protection and process data checks
  a_ot_chip_mask: assert property (ce && st.phase == FIOWD_RUN && drv_overtemp[N_CHIP-1]
    |=> st.ot_off[N_OUT-1 -: OUT_PER_CHIP] == '1)
    else $error("last chip outputs not all masked");
  a_wd_stopped: assert property (ce && st.phase == FIOWD_RUN && st.fault[FLT_WATCHDOG]
    |=> st.tick_cnt == 32'h00000000)
    else $error("watchdog kept counting after bite");
  a_field_quiet: assert property (ce && st.phase == FIOWD_RUN && !separate_supply
    |=> !st.field_lost)
    else $error("field loss reported on shared supply");
  a_analog_follow: assert property (ce && st.phase == FIOWD_RUN && (pd_mode == 2'h1 || pd_mode == 2'h2)
    |=> analog_in_0_3 == $past(in_level_code[3:0]))
    else $error("analog codes of inputs 0-3 not returned");
  a_field_report_mode: assert property (ce && st.phase == FIOWD_RUN && pd_mode != 2'h2
    |=> field_report == 8'h00)
    else $error("field code reported outside mode 2");

  c_wd_bite:    cover property ($rose(st.fault[FLT_WATCHDOG]));
  c_fault_clr:  cover property ($fell(|st.fault));
  c_out_driven: cover property (field_out != 16'h0000);
  c_oc_event:   cover property ($rose(st.fault[FLT_OVERCUR]));
  c_ot_event:   cover property ($rose(st.fault[FLT_OVERTEMP]));

endmodule // fiowd_top
`default_nettype wire

// >>> testbench/fiowd_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module fiowd_host_model (
  input  wire logic        clk,
  output logic             param_rd,
  output logic             param_wr,
  output logic [3:0]       param_sel,
  output logic [31:0]      param_wdata,
  input  wire logic [31:0] param_rdata,
  input  wire logic        param_ack,
  input  wire logic        param_err
);
  initial begin
    param_rd    = 1'b0;
    param_wr    = 1'b0;
    param_sel   = 4'hF;
    param_wdata = 32'h0;
  end

  // ==========================================
  // One access, request held until ack is sampled
  task automatic xfer(input logic wr, input logic [3:0] sel, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    param_wr    <= wr;
    param_rd    <= !wr;
    param_sel   <= sel;
    param_wdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (param_ack !== 1'b1 && n < 8);
    rd  = param_rdata;
    // No answer reads as an error so the caller counts it
    err = (param_ack === 1'b1) ? param_err : 1'b1;
    // Idle lines carry junk so a stale value never looks valid
    param_wr    <= 1'b0;
    param_rd    <= 1'b0;
    param_sel   <= ~sel;
    param_wdata <= ~wd;
  endtask
endmodule // fiowd_host_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fiowd_pkg::*;
  logic            clk, rst_b, ce, separate_supply;
  logic            param_rd, param_wr, param_ack, param_err;
  logic [3:0]      param_sel;
  logic [31:0]     param_wdata, param_rdata;
  logic [1:0]      pd_mode, drv_overtemp;
  logic [31:0][7:0] in_level_code;
  logic [7:0]      field_code, field_report;
  logic [15:0]     drv_overcurrent, field_out;
  logic [3:0][7:0] analog_in_0_3;
  logic            cfg_init_indicator, cfg_done_indicator;
  logic            field_power_indicator, logic_power_indicator, power_fail_indicator;
  int              failures, num_checks;

  fiowd_top #(.TICK_CYC(4)) dut (.clk(clk), .rst_b(rst_b), .ce(ce), .param_rd(param_rd),
    .param_wr(param_wr), .param_sel(param_sel), .param_wdata(param_wdata),
    .param_rdata(param_rdata), .param_ack(param_ack), .param_err(param_err),
    .pd_mode(pd_mode), .in_level_code(in_level_code), .field_code(field_code),
    .separate_supply(separate_supply), .drv_overcurrent(drv_overcurrent),
    .drv_overtemp(drv_overtemp), .field_out(field_out), .analog_in_0_3(analog_in_0_3),
    .field_report(field_report), .cfg_init_indicator(cfg_init_indicator),
    .cfg_done_indicator(cfg_done_indicator), .field_power_indicator(field_power_indicator),
    .logic_power_indicator(logic_power_indicator), .power_fail_indicator(power_fail_indicator));

  fiowd_host_model host (.clk(clk), .param_rd(param_rd), .param_wr(param_wr),
    .param_sel(param_sel), .param_wdata(param_wdata), .param_rdata(param_rdata),
    .param_ack(param_ack), .param_err(param_err));

  always #20 clk = ~clk;

  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, s, d, r, e);
    chk(32'(e), 32'h0);
  endtask
  task automatic rd_chk(input logic [3:0] s, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b0, s, 32'h0, r, e);
    chk(r, exp);
    chk(32'(e), 32'h0);
  endtask
  task automatic complete_run();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_powerup();
    chk(32'({cfg_init_indicator, cfg_done_indicator}), 32'h0);
    chk(32'({logic_power_indicator, field_power_indicator}), 32'h3);
    rd_chk(SEL_FAULT, 32'(RST_FAULT));
    rd_chk(SEL_STATUS, 32'h0000000D);
    rd_chk(SEL_NV_SPEED, 32'(RST_NV_SPEED));
    rd_chk(SEL_PERIOD, 32'(RST_NV_PERIOD));
    wr(SEL_OUTPUT, 32'h0000FFFF);
    cyc(2);
    chk(32'(field_out), 32'h0);
    rd_chk(SEL_OUTPUT, 32'h0);
    wr(SEL_FAULT, 32'h0000001F);
    rd_chk(SEL_STATUS, 32'h00000009);
    wr(SEL_OUTPUT, 32'h0000A5C3);
    cyc(1);
    chk(32'(field_out), 32'h0000A5C3);
    rd_chk(SEL_OUTPUT, 32'h0000A5C3);
    $display("test powerup done");
  endtask

  task automatic t_inputs();
    for (int i = 0; i < 32; i++) in_level_code[i] <= i[0] ? 8'h4F : 8'h78;
    cyc(3);
    rd_chk(SEL_INPUT, 32'h55555555);
    for (int i = 0; i < 32; i++) in_level_code[i] <= 8'h64;
    cyc(3);
    rd_chk(SEL_INPUT, 32'h55555555);
    for (int i = 0; i < 32; i++) in_level_code[i] <= i[0] ? 8'h78 : 8'h64;
    cyc(3);
    rd_chk(SEL_INPUT, 32'hFFFFFFFF);
    pd_mode <= 2'h1;
    cyc(3);
    chk(analog_in_0_3, 32'h78647864);
    chk(32'(field_report), 32'h0);
    pd_mode <= 2'h2;
    cyc(3);
    chk(analog_in_0_3, 32'h78647864);
    chk(32'(field_report), 32'h000000C8);
    pd_mode <= 2'h0;
    cyc(3);
    chk(analog_in_0_3, 32'h0);
    $display("test inputs done");
  endtask

  task automatic t_drivers();
    drv_overcurrent <= 16'h0008;
    cyc(2);
    chk(32'(field_out), 32'h0);
    drv_overcurrent <= 16'h0000;
    rd_chk(SEL_FAULT, 32'h00000002);
    wr(SEL_FAULT, 32'h00000002);
    wr(SEL_OUTPUT, 32'h0000FF00);
    cyc(1);
    chk(32'(field_out), 32'h0000FF00);
    drv_overtemp <= 2'h2;
    cyc(2);
    chk(32'(field_out), 32'h0);
    drv_overtemp <= 2'h0;
    rd_chk(SEL_FAULT, 32'h00000004);
    wr(SEL_FAULT, 32'h00000004);
    field_code <= 8'h20;
    cyc(3);
    chk(32'(power_fail_indicator), 32'h1);
    rd_chk(SEL_FAULT, 32'h00000008);
    field_code <= 8'hC8;
    wr(SEL_FAULT, 32'h00000008);
    cyc(2);
    chk(32'(power_fail_indicator), 32'h0);
    $display("test drivers done");
  endtask

  task automatic t_params();
    logic [31:0] r;
    logic        e;
    wr(SEL_UNIT, 32'h12345678);
    wr(SEL_NV_UNIT, 32'h0BADF00D);
    rd_chk(SEL_UNIT, 32'h12345678);
    rd_chk(SEL_NV_UNIT, 32'h0BADF00D);
    wr(SEL_NV_PERIOD, 32'h00000007);
    rd_chk(SEL_PERIOD, 32'(RST_NV_PERIOD));
    host.xfer(1'b0, 4'h9, 32'h0, r, e);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    $display("test params done");
  endtask

  task automatic t_watchdog();
    wr(SEL_OUTPUT, 32'h000000F0);
    wr(SEL_PERIOD, 32'h00000003);
    repeat (4) begin
      cyc(3);
      rd_chk(SEL_FAULT, 32'h0);
    end
    cyc(20);
    chk(32'(field_out), 32'h0);
    rd_chk(SEL_FAULT, 32'h00000001);
    wr(SEL_PERIOD, 32'h0);
    wr(SEL_FAULT, 32'h00000001);
    wr(SEL_OUTPUT, 32'h00000F0F);
    cyc(300);
    chk(32'(field_out), 32'h00000F0F);
    rd_chk(SEL_FAULT, 32'h0);
    // Clock enable low freezes the count, so no bite
    wr(SEL_PERIOD, 32'h00000003);
    ce <= 1'b0;
    cyc(40);
    chk(32'(field_out), 32'h00000F0F);
    ce <= 1'b1;
    rd_chk(SEL_FAULT, 32'h0);
    $display("test watchdog done");
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    separate_supply = 1'b1;
    pd_mode = 2'h0;
    in_level_code = '0;
    field_code = 8'hC8;
    drv_overcurrent = 16'h0000;
    drv_overtemp = 2'h0;
    failures = 0;
    num_checks = 0;
    cyc(4);
    rst_b <= 1'b1;
    cyc(3);
    t_powerup();
    t_inputs();
    t_drivers();
    t_params();
    t_watchdog();
    complete_run();
  end

  initial begin
    #(4000 * 40);
    failures++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
